/* File: design/clp_consts.vh */
`ifndef CLP_CONSTS_VH
`define CLP_CONSTS_VH

// Clock period and instruction execution time
`define CLP_CLK_NS 40
`define CLP_EXEC_NS 40000
`define CLP_EXEC_CYC ((`CLP_EXEC_NS + `CLP_CLK_NS - 1) / `CLP_CLK_NS)

// Fill code used by display clear
`define CLP_SPACE_CODE 8'h20

// Status byte layout
`define CLP_BIT_BUSY 7

// Function set fields
`define CLP_BIT_WIDTH 4
`define CLP_BIT_LINES 3
`define CLP_BIT_FONT 2

// Display on/off fields
`define CLP_BIT_DISP 2
`define CLP_BIT_CURS 1
`define CLP_BIT_BLINK 0

// Entry mode fields
`define CLP_BIT_INC 1
`define CLP_BIT_SHIFT 0

// Power-on defaults
`define CLP_RST_WIDTH 1'b1
`define CLP_RST_LINES 1'b0
`define CLP_RST_FONT 1'b0
`define CLP_RST_DISP 1'b0
`define CLP_RST_CURS 1'b0
`define CLP_RST_BLINK 1'b0
`define CLP_RST_INC 1'b1
`define CLP_RST_SHIFT 1'b0

`endif

/* File: design/clp_sync.v */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Three-stage pin synchroniser; output moves only when stages two and three agree
module clp_sync #(
    parameter WIDTH = 11
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] stable
);
    reg [WIDTH-1:0] s1;
    reg [WIDTH-1:0] s2;
    reg [WIDTH-1:0] s3;
    reg [WIDTH-1:0] hold;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1[i] <= 1'b0;
                    s2[i] <= 1'b0;
                    s3[i] <= 1'b0;
                    hold[i] <= 1'b0;
                end else begin
                    s1[i] <= pin_in[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        hold[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate

    assign stable = hold;
endmodule

/* File: design/clp_port.v */
`timescale 1ns/100ps
// Functional notes
// - Eight-line mode uses enable, register select, read/write and data bits 0-7.
// - Four-line mode uses enable, register select, read/write and data bits 4-7.
// - Four-line mode carries each byte as two nibble transfers.
// - Controller initializes itself at power-up with no host action.
// - Busy flag stays high until the whole power-on sequence completes.
// - Init defaults: eight-line, one line, 5x8 font, display/cursor/blink off.
// - Init entry mode: address counter increments, whole-display shift off.
// - Four-line mode sends upper nibble first, lower nibble second.
// - Four-line mode raises busy only after the second nibble ends.
// - Status read gives busy on bit 7, address counter on 6-0.
// - Width select set means eight-line mode, cleared means four-line mode.
`include "clp_consts.vh"

module clp_port #(
    parameter RAM_DEPTH = 128
) (
    input wire clk,
    input wire rst_n,
    input wire enable_pin,
    input wire register_select,
    input wire rw_select,
    input wire [7:0] data_lines_in,
    output reg [7:0] data_lines_out,
    output reg [7:0] data_lines_oe_n,
    output reg busy_flag,
    output reg width_select,
    output reg two_line,
    output reg font_large,
    output reg display_on,
    output reg cursor_on,
    output reg blink_on,
    output reg entry_increment,
    output reg entry_shift,
    output reg [6:0] addr_counter
);
    localparam [1:0] ST_CLEAR = 2'd0;
    localparam [1:0] ST_WAIT = 2'd1;
    localparam [1:0] ST_IDLE = 2'd2;
    // Full width first so the cut to the counter width is deliberate
    localparam [31:0] EXEC_FULL = `CLP_EXEC_CYC;
    localparam [11:0] EXEC_CYC = EXEC_FULL[11:0];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and strobe edges
    wire [10:0] pins_f;
    wire e_f = pins_f[10];
    wire rs_f = pins_f[9];
    wire rw_f = pins_f[8];
    wire [7:0] d_f = pins_f[7:0];

    clp_sync #(
        .WIDTH(11)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in({enable_pin, register_select, rw_select, data_lines_in}),
        .stable(pins_f)
    );

    reg e_prev;
    reg nib_phase;
    reg [3:0] hi_nib;
    reg [7:0] rd_byte;
    reg [1:0] state;
    reg por_run;
    reg [6:0] clr_addr;
    reg [11:0] busy_cnt;
    reg [7:0] ram [0:RAM_DEPTH-1];

    wire fall = e_prev & ~e_f;
    wire rise = ~e_prev & e_f;
    wire last_nib = width_select | nib_phase;
    wire wr_done = fall & ~rw_f & last_nib;
    wire [7:0] exec_byte = width_select ? d_f : {hi_nib, d_f[7:4]};
    // Host writes while busy are dropped; the host must poll first
    wire host_go = wr_done & (state == ST_IDLE);
    wire [6:0] ac_step = entry_increment ? addr_counter + 7'h01 : addr_counter - 7'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Display text RAM, no reset so it maps onto memory
    always @(posedge clk) begin
        if (state == ST_CLEAR) begin
            ram[clr_addr] <= `CLP_SPACE_CODE;
        end else if (host_go & rs_f) begin
            ram[addr_counter] <= exec_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: data lines driven only while enable is high on a read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            e_prev <= 1'b0;
            rd_byte <= 8'h00;
            data_lines_out <= 8'h00;
            data_lines_oe_n <= 8'hFF;
        end else begin
            e_prev <= e_f;
            if (rise & rw_f & ~nib_phase) begin
                // Byte frozen on the first nibble so both halves match
                rd_byte <= rs_f ? ram[addr_counter] : {busy_flag, addr_counter};
            end
            if (e_f & rw_f) begin
                data_lines_oe_n <= width_select ? 8'h00 : 8'h0F;
            end else begin
                data_lines_oe_n <= 8'hFF;
            end
            if (width_select) begin
                data_lines_out <= rd_byte;
            end else if (nib_phase) begin
                data_lines_out <= {rd_byte[3:0], 4'h0};
            end else begin
                data_lines_out <= {rd_byte[7:4], 4'h0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control: power-on sequence, nibble pairing, instruction execution
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_CLEAR;
            por_run <= 1'b1;
            clr_addr <= 7'h00;
            busy_cnt <= 12'h000;
            busy_flag <= 1'b1;
            nib_phase <= 1'b0;
            hi_nib <= 4'h0;
            width_select <= `CLP_RST_WIDTH;
            two_line <= `CLP_RST_LINES;
            font_large <= `CLP_RST_FONT;
            display_on <= `CLP_RST_DISP;
            cursor_on <= `CLP_RST_CURS;
            blink_on <= `CLP_RST_BLINK;
            entry_increment <= `CLP_RST_INC;
            entry_shift <= `CLP_RST_SHIFT;
            addr_counter <= 7'h00;
        end else begin
            // Nibble pairing runs even while busy so status polls stay aligned
            if (fall & ~width_select) begin
                if (!nib_phase) begin
                    hi_nib <= d_f[7:4];
                end
                nib_phase <= ~nib_phase;
            end
            if (fall & rw_f & last_nib & rs_f) begin
                addr_counter <= ac_step;
            end
            case (state)
                ST_CLEAR: begin
                    busy_flag <= 1'b1;
                    clr_addr <= clr_addr + 7'h01;
                    if (clr_addr == RAM_DEPTH - 1) begin
                        clr_addr <= 7'h00;
                        addr_counter <= 7'h00;
                        if (por_run) begin
                            width_select <= `CLP_RST_WIDTH;
                            two_line <= `CLP_RST_LINES;
                            font_large <= `CLP_RST_FONT;
                            display_on <= `CLP_RST_DISP;
                            cursor_on <= `CLP_RST_CURS;
                            blink_on <= `CLP_RST_BLINK;
                            entry_increment <= `CLP_RST_INC;
                            entry_shift <= `CLP_RST_SHIFT;
                            nib_phase <= 1'b0;
                        end
                        busy_cnt <= EXEC_CYC;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (busy_cnt <= 12'h001) begin
                        busy_cnt <= 12'h000;
                        busy_flag <= 1'b0;
                        por_run <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        busy_cnt <= busy_cnt - 12'h001;
                    end
                end
                ST_IDLE: begin
                    if (host_go) begin
                        busy_flag <= 1'b1;
                        busy_cnt <= EXEC_CYC;
                        state <= ST_WAIT;
                        if (rs_f) begin
                            addr_counter <= ac_step;
                        end else begin
                            // Host-driven init uses these same instructions
                            casez (exec_byte)
                                8'b1???????: begin
                                    addr_counter <= exec_byte[6:0];
                                end
                                8'b01??????: begin
                                    addr_counter <= addr_counter;
                                end
                                8'b001?????: begin
                                    width_select <= exec_byte[`CLP_BIT_WIDTH];
                                    two_line <= exec_byte[`CLP_BIT_LINES];
                                    font_large <= exec_byte[`CLP_BIT_FONT];
                                    nib_phase <= 1'b0;
                                end
                                8'b0001????: begin
                                    if (!exec_byte[3]) begin
                                        addr_counter <= exec_byte[2] ? addr_counter + 7'h01
                                            : addr_counter - 7'h01;
                                    end
                                end
                                8'b00001???: begin
                                    display_on <= exec_byte[`CLP_BIT_DISP];
                                    cursor_on <= exec_byte[`CLP_BIT_CURS];
                                    blink_on <= exec_byte[`CLP_BIT_BLINK];
                                end
                                8'b000001??: begin
                                    entry_increment <= exec_byte[`CLP_BIT_INC];
                                    entry_shift <= exec_byte[`CLP_BIT_SHIFT];
                                end
                                8'b0000001?: begin
                                    addr_counter <= 7'h00;
                                end
                                8'b00000001: begin
                                    clr_addr <= 7'h00;
                                    state <= ST_CLEAR;
                                end
                                default: begin
                                    busy_cnt <= EXEC_CYC;
                                end
                            endcase
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: tb/clp_port_properties.sv */
`timescale 1ns/100ps
module clp_port_props (
    input wire clk,
    input wire rst_n,
    input wire enable_pin,
    input wire rw_select,
    input wire [7:0] data_lines_out,
    input wire [7:0] data_lines_oe_n,
    input wire busy_flag,
    input wire width_select,
    input wire two_line,
    input wire font_large,
    input wire display_on,
    input wire cursor_on,
    input wire blink_on,
    input wire entry_increment,
    input wire entry_shift,
    input wire [6:0] addr_counter
);
    reg [10:0] init_cnt;
    // Saturates so the power-on checks fire once per reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) init_cnt <= 11'h000;
        else if (init_cnt != 11'h7FF) init_cnt <= init_cnt + 11'h001;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_init_busy;
        init_cnt < 11'h44C |-> busy_flag;
    endproperty
    a_init_busy: assert property (p_init_busy) else $error("busy low during power-on sequence");
    property p_init_mode;
        init_cnt == 11'h474 |-> !busy_flag && width_select && entry_increment && !entry_shift && addr_counter == 7'h00;
    endproperty
    a_init_mode: assert property (p_init_mode) else $error("power-on mode defaults wrong");
    property p_init_disp;
        init_cnt == 11'h474 |-> (|{display_on, cursor_on, blink_on, two_line, font_large}) == 1'b0;
    endproperty
    a_init_disp: assert property (p_init_disp) else $error("power-on display defaults wrong");
    property p_oe_shape;
        data_lines_oe_n != 8'hFF |-> data_lines_oe_n == (width_select ? 8'h00 : 8'h0F);
    endproperty
    a_oe_shape: assert property (p_oe_shape) else $error("drive enable not matching bus width");
    property p_oe_read;
        data_lines_oe_n != 8'hFF |-> rw_select;
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("data lines driven during write");
    property p_oe_release;
        $fell(enable_pin) ##1 !enable_pin [*7] |-> data_lines_oe_n == 8'hFF;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("data lines still driven after strobe low");
    property p_nibble_low;
        data_lines_oe_n == 8'h0F && $past(data_lines_oe_n) == 8'h0F |-> data_lines_out[3:0] == 4'h0;
    endproperty
    a_nibble_low: assert property (p_nibble_low) else $error("lower lines not zero in four-line read");
    property p_flags_exec;
        $changed({width_select, two_line, font_large, display_on, cursor_on, blink_on}) |-> $rose(busy_flag);
    endproperty
    a_flags_exec: assert property (p_flags_exec) else $error("mode changed without busy start");
    property p_exec_hold;
        $rose(busy_flag) |-> ##300 busy_flag;
    endproperty
    a_exec_hold: assert property (p_exec_hold) else $error("busy too short");
endmodule

/* File: tb/clp_host.sv */
`timescale 1ns/100ps
module clp_host (
    input wire clk,
    input wire [7:0] bus,
    output reg e,
    output reg rs,
    output reg rw,
    output reg [7:0] hd,
    output reg hoe
);
    reg four;
    reg stuck;
    initial begin
        stuck = 1'b0;
        e = 1'b0; rs = 1'b0; rw = 1'b1; hd = 8'h00; hoe = 1'b0; four = 1'b0;
    end
    ////////////////////////////////////////
    // Each phase 8 cycles so the 3-flop pin filter always settles
    task xfer(input r, input w, input [7:0] d, output [7:0] q);
        begin
            @(posedge clk) #1;
            rs = r; rw = w; hd = d; hoe = !w; e = 1'b1;
            repeat (8) @(posedge clk);
            #1 q = bus;
            e = 1'b0;
            repeat (8) @(posedge clk);
            #1 hoe = 1'b0;
        end
    endtask
    task put(input r, input [7:0] d);
        reg [7:0] q;
        begin
            if (four) begin
                xfer(r, 1'b0, {d[7:4], d[3:0]}, q);
                xfer(r, 1'b0, {d[3:0], d[7:4]}, q);
            end else begin
                xfer(r, 1'b0, d, q);
            end
        end
    endtask
    task get(input r, output [7:0] q);
        reg [7:0] a;
        reg [7:0] b;
        begin
            xfer(r, 1'b1, 8'h00, a);
            b = a;
            if (four) xfer(r, 1'b1, 8'h00, b);
            q = four ? {a[7:4], b[7:4]} : a;
        end
    endtask
    // Bounded so a stuck flag cannot hang the host
    task ready;
        reg [7:0] s;
        integer n;
        begin
            s = 8'h80;
            n = 0;
            while (s[7] === 1'b1 && n < 200) begin
                get(1'b0, s);
                n = n + 1;
            end
            if (s[7] !== 1'b0) begin
                stuck = 1'b1;
            end
        end
    endtask
endmodule

/* File: tb/clp_port_tb.sv */
`timescale 1ns/100ps
module clp_port_tb;
    reg clk;
    reg rst_n;
    wire e, rs, rw, hoe, busy, wsel, two, font, disp, curs, blink, inc, shift;
    wire [7:0] hd, dout, oe_n, bus;
    integer n_errors;
    integer check_count;
    reg [7:0] q;
    // Undriven lines show the inverse of the last host value
    assign bus = (~oe_n & dout) | (oe_n & (hoe ? hd : ~hd));
    clp_port clp_port_i (.clk(clk), .rst_n(rst_n), .enable_pin(e), .register_select(rs), .rw_select(rw),
        .data_lines_in(bus), .data_lines_out(dout), .data_lines_oe_n(oe_n), .busy_flag(busy),
        .width_select(wsel), .two_line(two), .font_large(font), .display_on(disp), .cursor_on(curs),
        .blink_on(blink), .entry_increment(inc), .entry_shift(shift), .addr_counter());
    clp_host clp_host_i (.clk(clk), .bus(bus), .e(e), .rs(rs), .rw(rw), .hd(hd), .hoe(hoe));
    ////////////////////////////////////////
    task check(input [7:0] seen, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task final_report;
        begin
            n_errors = n_errors + clp_host_i.stuck;
            $display("checks %0d errors %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task cmd(input r, input [7:0] d);
        begin
            clp_host_i.ready;
            clp_host_i.put(r, d);
        end
    endtask
    task rd(input r, input [7:0] exp);
        begin
            clp_host_i.ready;
            clp_host_i.get(r, q);
            check(q, exp);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_errors = n_errors + 1;
        final_report;
    end
    initial begin
        n_errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        clp_host_i.get(1'b0, q);
        check(q, 8'h80);
        clp_host_i.ready;
        check({wsel, two, font, disp, curs, blink, inc, shift}, 8'h82);
        rd(1'b0, 8'h00);
        cmd(1'b0, 8'hFF);
        rd(1'b1, 8'h20);
        rd(1'b0, 8'h00);
        rd(1'b1, 8'h20);
        rd(1'b0, 8'h01);
        cmd(1'b0, 8'h0F);
        check({4'h0, busy, disp, curs, blink}, 8'h0F);
        cmd(1'b0, 8'h85);
        cmd(1'b1, 8'hA5);
        rd(1'b0, 8'h06);
        cmd(1'b0, 8'h85);
        rd(1'b1, 8'hA5);
        cmd(1'b0, 8'h28);
        clp_host_i.four = 1'b1;
        clp_host_i.ready;
        check({6'h00, wsel, two}, 8'h01);
        cmd(1'b0, 8'h8A);
        clp_host_i.ready;
        clp_host_i.xfer(1'b1, 1'b0, 8'h35, q);
        check({7'h00, busy}, 8'h00);
        clp_host_i.xfer(1'b1, 1'b0, 8'hC3, q);
        check({7'h00, busy}, 8'h01);
        cmd(1'b0, 8'h8A);
        rd(1'b1, 8'h3C);
        rd(1'b0, 8'h0B);
        cmd(1'b0, 8'h30);
        clp_host_i.four = 1'b0;
        clp_host_i.ready;
        check({7'h00, wsel}, 8'h01);
        cmd(1'b0, 8'h14);
        rd(1'b0, 8'h0C);
        cmd(1'b0, 8'h10);
        rd(1'b0, 8'h0B);
        cmd(1'b0, 8'h04);
        clp_host_i.ready;
        check({6'h00, inc, shift}, 8'h00);
        cmd(1'b1, 8'h5A);
        rd(1'b0, 8'h0A);
        rd(1'b1, 8'h3C);
        rd(1'b0, 8'h09);
        cmd(1'b0, 8'h02);
        rd(1'b0, 8'h00);
        cmd(1'b0, 8'h01);
        cmd(1'b0, 8'h8B);
        rd(1'b1, 8'h20);
        rd(1'b0, 8'h0A);
        cmd(1'b1, 8'h77);
        cmd(1'b0, 8'h8A);
        rd(1'b1, 8'h77);
        // Second power-on: defaults and blank text must come back
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        clp_host_i.get(1'b0, q);
        check(q, 8'h80);
        clp_host_i.ready;
        check({wsel, two, font, disp, curs, blink, inc, shift}, 8'h82);
        cmd(1'b0, 8'h8A);
        rd(1'b1, 8'h20);
        final_report;
    end
endmodule
bind clp_port clp_port_props clp_port_props_i (.clk(clk), .rst_n(rst_n), .enable_pin(enable_pin),
    .rw_select(rw_select), .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
    .busy_flag(busy_flag), .width_select(width_select), .two_line(two_line), .font_large(font_large),
    .display_on(display_on), .cursor_on(cursor_on), .blink_on(blink_on),
    .entry_increment(entry_increment), .entry_shift(entry_shift), .addr_counter(addr_counter));
